// File: hw/job_status_error_report.sv
// Job status records, bulk status word, result byte and coordination flags.
// Assumes the handshake engine and transfer sequencer drive synchronous events.
//
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module job_status_error_report import job_status_pkg::*; (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_cyc_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire hs_req_s     hs_i,
	input  wire logic        xchg_end_i,
	output hs_rsp_s          hs_o,
	input  wire job_evt_s    job_i,
	input  wire bulk_evt_s   bulk_i,
	input  wire logic [7:0]  partner_flag_i,
	output logic             partner_grant_o,
	output logic [7:0]       bulk_status_o
);
	logic [15:0] stat_q [N_JOBS];
	logic [15:0] len_q  [N_JOBS];
	logic [31:0] flag_q [8];
	logic [4:0]  qcnt_q;
	logic        synced_q;
	logic        busy_q;
	logic [1:0]  owner_q;
	logic [7:0]  pe_q;
	hs_rsp_s     rsp_q;
	logic [7:0]  bulk_q;
	logic        grant_q;
	logic [7:0]  sel_q;
	logic        ack_q;
	logic [31:0] dat_q;
	logic [7:0]  code_d;
	logic        acc;
	logic        qrej;
	logic        sync_ok;
	logic        req_ok;
	logic        evt_ok;
	logic        running;
	logic        dec;
	logic        special;
	logic [15:0] evt_len;
	logic [7:0]  bulk_d;
	logic        wb_req;

	////////////////////////////////////////////////////////////////////////////
	// Handshake checks.

	function automatic logic [7:0] fault_code(input fault_e f);
		unique case (f)
			F_NONE:      fault_code = PE_OK;
			F_AREA_FMT:  fault_code = PE_AREA_FMT;
			F_NO_BLOCK:  fault_code = PE_NO_BLOCK;
			F_TOO_SMALL: fault_code = PE_TOO_SMALL;
			F_NOT_EQUIP: fault_code = PE_NOT_EQUIP;
			F_STAT_WORD: fault_code = PE_STAT_WORD;
			F_NO_PARAMS: fault_code = PE_NO_PARAMS;
			F_NO_IFACE:  fault_code = PE_NO_IFACE;
			F_DOWNLOAD:  fault_code = PE_OVERLOAD;
			F_NO_REPLY:  fault_code = PE_HS_FAIL;
			F_FLAG_RACE: fault_code = PE_HS_FAIL;
			F_HS_OTHER:  fault_code = PE_HS_OTHER;
			F_INTERNAL:  fault_code = PE_INTERNAL;
			default:     fault_code = PE_INTERNAL;
		endcase
	endfunction

	assign req_ok  = hs_i.job <= JOB_MAX;
	assign evt_ok  = job_i.job <= JOB_MAX;
	assign running = req_ok && stat_q[req_ok ? hs_i.job : 8'h00][1];

	// The order below decides which code wins when several faults coincide.
	always_comb begin
		code_d  = PE_OK;
		acc     = 1'b0;
		qrej    = 1'b0;
		sync_ok = 1'b0;
		if (busy_q && owner_q == hs_i.cpu) begin
			code_d = PE_REENTRY;
		end else if (busy_q) begin
			code_d = PE_BUSY;
		end else if (hs_i.fault == F_NO_IFACE || hs_i.fault == F_DOWNLOAD) begin
			code_d = fault_code(hs_i.fault);
		end else if (hs_i.kind == K_SYNC) begin
			if (hs_i.frame_ok) begin
				sync_ok = hs_i.valid;
			end else begin
				code_d = PE_HS_OTHER;
			end
		end else if (!synced_q && (hs_i.kind == K_SEND || hs_i.kind == K_FETCH)) begin
			code_d = PE_NOT_READY;
		end else if (!req_ok) begin
			code_d = PE_JOB_BIG;
		end else if (hs_i.fault != F_NONE) begin
			code_d = fault_code(hs_i.fault);
		end else if ((hs_i.kind == K_SEND || hs_i.kind == K_FETCH) && hs_i.job != 8'h00) begin
			if (running) begin
				code_d = PE_HS_FAIL;
			end else if (qcnt_q == Q_DEPTH) begin
				code_d = PE_HS_FAIL;
				qrej   = hs_i.valid;
			end else begin
				acc = hs_i.valid;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Result byte and page ownership.

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pe_q  <= PE_OK;
			rsp_q <= '0;
		end else begin
			rsp_q.valid <= hs_i.valid;
			rsp_q.code  <= code_d;
			if (hs_i.valid) begin
				pe_q <= code_d;
			end
		end
	end

	// A page stays with its CPU until the processor ends the exchange.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_q  <= 1'b0;
			owner_q <= 2'h0;
		end else if (hs_i.valid && !busy_q) begin
			busy_q  <= 1'b1;
			owner_q <= hs_i.cpu;
		end else if (xchg_end_i) begin
			busy_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			synced_q <= 1'b0;
		end else if (sync_ok) begin
			synced_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Queue occupancy and job records.

	assign dec = (job_i.done_ok || job_i.done_err) && evt_ok && stat_q[evt_ok ? job_i.job : 8'h00][1];
	assign evt_len = len_q[evt_ok ? job_i.job : 8'h00];
	assign special = job_i.job == SPJ_A || job_i.job == SPJ_B || job_i.job == SPJ_C ||
		job_i.job == SPJ_D || job_i.job == SPJ_E;

	always_ff @(posedge clk_i) begin
		if (rst_i || sync_ok) begin
			qcnt_q <= 5'h00;
		end else begin
			qcnt_q <= qcnt_q + {4'h0, acc} - {4'h0, dec};
		end
	end

	for (genvar g = 0; g < N_JOBS; g++) begin : g_job
		logic hit_r;
		logic hit_e;
		assign hit_r = hs_i.job == 8'(g);
		assign hit_e = job_i.job == 8'(g);
		always_ff @(posedge clk_i) begin
			if (rst_i || sync_ok) begin
				stat_q[g] <= 16'h0000;
			end else if (acc && hit_r) begin
				stat_q[g] <= ST_RUNNING;
			end else if (qrej && hit_r) begin
				stat_q[g] <= ST_DONE_ERR | {4'h0, ST_QFULL, 8'h00};
			end else if (hit_e && job_i.long_dest && special) begin
				stat_q[g] <= ST_DONE_ERR | {ST_LONG_DEST, 8'h00};
			end else if (hit_e && job_i.done_err) begin
				stat_q[g] <= ST_DONE_ERR | {4'h0, job_i.code, 8'h00};
			end else if (hit_e && job_i.done_ok) begin
				stat_q[g] <= ST_DONE_OK;
			end
		end
		always_ff @(posedge clk_i) begin
			if (rst_i || sync_ok) begin
				len_q[g] <= 16'h0000;
			end else if (acc && hit_r) begin
				len_q[g] <= 16'h0000;
			end else if (hit_e && job_i.xfer) begin
				len_q[g] <= len_q[g] + job_i.len;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bulk status word and coordination flags.

	always_comb begin
		bulk_d = BULK_IDLE;
		if (bulk_i.valid && !bulk_i.partner) begin
			bulk_d = bulk_i.job;
		end else if (bulk_i.valid && !bulk_i.last) begin
			bulk_d = BULK_PARTNER;
		end else if (bulk_i.valid && !bulk_i.has_flag) begin
			bulk_d = BULK_NO_FLAG;
		end else if (bulk_i.valid) begin
			bulk_d = (bulk_i.flag != 8'h00 && bulk_i.flag <= JOB_MAX) ? bulk_i.flag : BULK_OVER;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bulk_q  <= BULK_IDLE;
			grant_q <= 1'b0;
		end else begin
			bulk_q  <= bulk_d;
			grant_q <= !flag_q[partner_flag_i[7:5]][partner_flag_i[4:0]];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Wishbone slave: one wait state, writes land on the acknowledging edge.

	assign wb_req = wb_cyc_i && wb_stb_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_req && !ack_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_q <= 32'h0000_0000;
		end else if (wb_req && !ack_q) begin
			dat_q <= 32'h0000_0000;
			if (wb_adr_i[7:5] == A_FLAG_HI) begin
				dat_q <= flag_q[wb_adr_i[4:2]];
			end else begin
				unique case (wb_adr_i)
					A_SEL:  dat_q <= {24'h0, sel_q};
					A_STAT: dat_q <= {16'h0, (sel_q <= JOB_MAX) ? stat_q[sel_q] : 16'h0000};
					A_LEN:  dat_q <= {16'h0, (sel_q <= JOB_MAX) ? len_q[sel_q] : 16'h0000};
					A_BULK: dat_q <= {24'h0, bulk_q};
					A_PE:   dat_q <= {24'h0, pe_q};
					A_IF:   dat_q <= {24'h0, synced_q, busy_q, 1'b0, qcnt_q};
					default: dat_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sel_q <= 8'h00;
		end else if (wb_req && ack_q && wb_we_i && wb_adr_i == A_SEL && wb_sel_i[0]) begin
			sel_q <= wb_dat_i[7:0];
		end
	end

	// Flags belong to the host; only software sets or clears them.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 8; i++) begin
				flag_q[i] <= 32'h0000_0000;
			end
		end else if (wb_req && ack_q && wb_we_i && wb_adr_i[7:5] == A_FLAG_HI) begin
			for (int b = 0; b < 4; b++) begin
				if (wb_sel_i[b]) begin
					flag_q[wb_adr_i[4:2]][8*b +: 8] <= wb_dat_i[8*b +: 8];
				end
			end
		end
	end

	assign wb_ack_o        = ack_q;
	assign wb_dat_o        = dat_q;
	assign hs_o            = rsp_q;
	assign bulk_status_o   = bulk_q;
	assign partner_grant_o = grant_q;

	////////////////////////////////////////////////////////////////////////////
	// Assertions.

	logic [7:0]  hj_q;
	logic [7:0]  ej_q;
	always_ff @(posedge clk_i) begin
		hj_q <= req_ok ? hs_i.job : 8'h00;
		ej_q <= evt_ok ? job_i.job : 8'h00;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_accept;
		acc |=> stat_q[hj_q] == ST_RUNNING && len_q[hj_q] == 16'h0000 && hs_o.code == PE_OK;
	endproperty
	a_accept: assert property (p_accept) else $error("accepted job not marked running");

	property p_qfull;
		qrej |=> stat_q[hj_q][11:8] == ST_QFULL && stat_q[hj_q][3] && hs_o.code == PE_HS_FAIL;
	endproperty
	a_qfull: assert property (p_qfull) else $error("full queue not reported");

	property p_done_ok;
		job_i.done_ok && !job_i.done_err && !job_i.long_dest && evt_ok && !acc && !qrej && !sync_ok
			|=> stat_q[ej_q] == ST_DONE_OK;
	endproperty
	a_done_ok: assert property (p_done_ok) else $error("clean completion not shown");

	property p_err_code;
		job_i.done_err && !job_i.long_dest && evt_ok && !acc && !qrej && !sync_ok
			|=> stat_q[ej_q][3] && stat_q[ej_q][11:8] == $past(job_i.code);
	endproperty
	a_err_code: assert property (p_err_code) else $error("error code not stored");

	property p_len_add;
		job_i.xfer && evt_ok && !(acc && hs_i.job == job_i.job) && !sync_ok
			|=> len_q[ej_q] == 16'($past(evt_len) + $past(job_i.len));
	endproperty
	a_len_add: assert property (p_len_add) else $error("length not accumulated");

	property p_bulk_idle;
		!bulk_i.valid |=> bulk_status_o == BULK_IDLE;
	endproperty
	a_bulk_idle: assert property (p_bulk_idle) else $error("idle bulk status not 00");

	property p_bulk_over;
		bulk_i.valid && bulk_i.partner && bulk_i.last && bulk_i.has_flag && bulk_i.flag > JOB_MAX
			|=> bulk_status_o == BULK_OVER;
	endproperty
	a_bulk_over: assert property (p_bulk_over) else $error("oversized flag not FF");

	property p_bulk_partner;
		bulk_i.valid && bulk_i.partner && !bulk_i.last |=> bulk_status_o == BULK_PARTNER;
	endproperty
	a_bulk_partner: assert property (p_bulk_partner) else $error("partner step not FF");

	// Special jobs bypass the queue, so only a clear, an accept or a queue-full refusal can mask this update.
	property p_long_dest;
		job_i.long_dest && special && !acc && !qrej && !sync_ok
			|=> stat_q[ej_q][15:8] == ST_LONG_DEST && stat_q[ej_q][3];
	endproperty
	a_long_dest: assert property (p_long_dest) else $error("oversized length not reported");

	property p_flag_block;
		flag_q[partner_flag_i[7:5]][partner_flag_i[4:0]] |=> !partner_grant_o;
	endproperty
	a_flag_block: assert property (p_flag_block) else $error("partner granted past set flag");

	property p_page_busy;
		hs_i.valid && busy_q && hs_i.cpu != owner_q |=> hs_o.valid && hs_o.code == PE_BUSY;
	endproperty
	a_page_busy: assert property (p_page_busy) else $error("busy page not refused");

	property p_unsynced;
		hs_i.valid && !busy_q && !synced_q && hs_i.kind == K_SEND && hs_i.fault == F_NONE
			|=> hs_o.valid && hs_o.code == PE_NOT_READY && pe_q == PE_NOT_READY;
	endproperty
	a_unsynced: assert property (p_unsynced) else $error("unsynchronised send accepted");

	property p_sync_clear;
		sync_ok |=> qcnt_q == 5'h00 && synced_q;
	endproperty
	a_sync_clear: assert property (p_sync_clear) else $error("sync did not clear queue");

	c_accept: cover property (acc ##1 job_i.done_ok);
	c_qfull: cover property (qrej);
	c_long: cover property (job_i.long_dest && special);
	c_flag: cover property (bulk_i.valid && bulk_i.partner && bulk_i.last && bulk_i.has_flag);
endmodule // job_status_error_report
`default_nettype wire

// File: hw/job_status_pkg.sv
// Constants, codes and carriers for the job status and error report block.
// Assumes one 10 MHz clock and a classic Wishbone register port.
package job_status_pkg;
	localparam int       N_JOBS   = 224;
	localparam logic [7:0] JOB_MAX  = 8'hDF;
	localparam logic [4:0] Q_DEPTH  = 5'h14;
	localparam logic [15:0] ST_RUNNING  = 16'h0002;
	localparam logic [15:0] ST_DONE_OK  = 16'h0004;
	localparam logic [15:0] ST_DONE_ERR = 16'h0008;
	localparam logic [3:0] ST_QFULL    = 4'h7;
	localparam logic [7:0] ST_LONG_DEST = 8'h15;
	localparam logic [7:0] SPJ_A = 8'hC8;
	localparam logic [7:0] SPJ_B = 8'hCA;
	localparam logic [7:0] SPJ_C = 8'hCC;
	localparam logic [7:0] SPJ_D = 8'hDA;
	localparam logic [7:0] SPJ_E = 8'hDD;
	localparam logic [7:0] BULK_IDLE    = 8'h00;
	localparam logic [7:0] BULK_PARTNER = 8'hFF;
	localparam logic [7:0] BULK_NO_FLAG = 8'hDE;
	localparam logic [7:0] BULK_OVER    = 8'hFF;
	localparam logic [7:0] PE_OK        = 8'h00;
	localparam logic [7:0] PE_AREA_FMT  = 8'h11;
	localparam logic [7:0] PE_NO_BLOCK  = 8'h21;
	localparam logic [7:0] PE_TOO_SMALL = 8'h31;
	localparam logic [7:0] PE_NOT_EQUIP = 8'h41;
	localparam logic [7:0] PE_STAT_WORD = 8'h51;
	localparam logic [7:0] PE_NO_PARAMS = 8'h61;
	localparam logic [7:0] PE_NO_IFACE  = 8'h71;
	localparam logic [7:0] PE_NOT_READY = 8'h81;
	localparam logic [7:0] PE_OVERLOAD  = 8'h91;
	localparam logic [7:0] PE_BUSY      = 8'hA1;
	localparam logic [7:0] PE_JOB_BIG   = 8'hB1;
	localparam logic [7:0] PE_HS_FAIL   = 8'hC1;
	localparam logic [7:0] PE_HS_OTHER  = 8'hD1;
	localparam logic [7:0] PE_INTERNAL  = 8'hE1;
	localparam logic [7:0] PE_REENTRY   = 8'hF1;
	localparam logic [7:0] A_SEL  = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_LEN  = 8'h08;
	localparam logic [7:0] A_BULK = 8'h0C;
	localparam logic [7:0] A_PE   = 8'h10;
	localparam logic [7:0] A_IF   = 8'h14;
	localparam logic [2:0] A_FLAG_HI = 3'h1;
	typedef enum logic [2:0] {K_SYNC, K_SEND, K_FETCH, K_RECV, K_OTHER} hs_kind_e;
	typedef enum logic [3:0] {F_NONE, F_AREA_FMT, F_NO_BLOCK, F_TOO_SMALL, F_NOT_EQUIP, F_STAT_WORD,
		F_NO_PARAMS, F_NO_IFACE, F_DOWNLOAD, F_NO_REPLY, F_FLAG_RACE, F_HS_OTHER, F_INTERNAL} fault_e;
	typedef struct packed {
		logic       valid;
		hs_kind_e   kind;
		logic [1:0] cpu;
		logic [7:0] job;
		logic       frame_ok;
		fault_e     fault;
	} hs_req_s;
	typedef struct packed {
		logic       valid;
		logic [7:0] code;
	} hs_rsp_s;
	typedef struct packed {
		logic        done_ok;
		logic        done_err;
		logic [3:0]  code;
		logic [7:0]  job;
		logic        xfer;
		logic [15:0] len;
		logic        long_dest;
	} job_evt_s;
	typedef struct packed {
		logic       valid;
		logic       partner;
		logic       last;
		logic       has_flag;
		logic [7:0] flag;
		logic [7:0] job;
	} bulk_evt_s;
endpackage

// File: verif/host_cpu_model.sv
// Host CPU model that issues handling-block invocations and closes exchanges.
// Assumes the block answers each invocation within a few clock cycles.
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model import job_status_pkg::*; (
	input  wire hs_rsp_s rsp_i,
	input  wire logic    clk_i,
	output hs_req_s      req_o,
	output logic         xchg_end_o
);
	initial begin
		req_o = '0;
		xchg_end_o = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// The exchange is closed only on request, so that page locking can be probed.
	task automatic invoke(input hs_kind_e k, input logic [1:0] c, input logic [7:0] j, input logic fok,
		input fault_e f, input logic fin, output logic [7:0] code);
		int n;
		code = 8'hEE;
		@(posedge clk_i);
		req_o <= '{1'b1, k, c, j, fok, f};
		@(posedge clk_i);
		req_o <= '0;
		for (n = 0; n < 8; n++) begin
			@(posedge clk_i);
			if (rsp_i.valid === 1'b1) begin
				code = rsp_i.code;
				break;
			end
		end
		if (fin) begin
			@(posedge clk_i);
			xchg_end_o <= 1'b1;
			@(posedge clk_i);
			xchg_end_o <= 1'b0;
		end
	endtask
endmodule // host_cpu_model
`default_nettype wire

// File: verif/job_status_error_report_test.sv
// Self-checking bench for the job status and error report block.
// Assumes a host CPU model on the handshake and direct drive of event inputs.
`timescale 1ns/1ps
`default_nettype none
module job_status_error_report_test import job_status_pkg::*;;
	logic        clk_i;
	logic        rst_i;
	logic [7:0]  wb_adr;
	logic [31:0] wb_wdat;
	logic [31:0] wb_rdat;
	logic [31:0] q;
	logic [3:0]  wb_sel;
	logic        wb_we;
	logic        wb_stb;
	logic        wb_cyc;
	logic        wb_ack;
	hs_req_s     hs_req;
	hs_rsp_s     hs_rsp;
	logic        xchg_end;
	job_evt_s    job_evt;
	bulk_evt_s   bulk_evt;
	logic [7:0]  pflag;
	logic [7:0]  bulk_st;
	logic        grant;
	int          fails;
	int          samples_checked;
	int          cycles = 0;
	fault_e      fl [12] = '{F_AREA_FMT, F_NO_BLOCK, F_TOO_SMALL, F_NOT_EQUIP, F_STAT_WORD, F_NO_PARAMS,
		F_NO_IFACE, F_DOWNLOAD, F_NO_REPLY, F_FLAG_RACE, F_HS_OTHER, F_INTERNAL};
	logic [7:0]  fc [12] = '{PE_AREA_FMT, PE_NO_BLOCK, PE_TOO_SMALL, PE_NOT_EQUIP, PE_STAT_WORD,
		PE_NO_PARAMS, PE_NO_IFACE, PE_OVERLOAD, PE_HS_FAIL, PE_HS_FAIL, PE_HS_OTHER, PE_INTERNAL};
	logic [7:0]  sp [5] = '{SPJ_A, SPJ_B, SPJ_C, SPJ_D, SPJ_E};
	bulk_evt_s   bt [7] = '{'{1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h07}, '{1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 8'h07},
		'{1'b1, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00}, '{1'b1, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00},
		'{1'b1, 1'b1, 1'b1, 1'b1, 8'h01, 8'h00}, '{1'b1, 1'b1, 1'b1, 1'b1, 8'hDF, 8'h00},
		'{1'b1, 1'b1, 1'b1, 1'b1, 8'hE0, 8'h00}};
	logic [7:0]  bx [7] = '{BULK_IDLE, 8'h07, BULK_PARTNER, BULK_NO_FLAG, 8'h01, 8'hDF, BULK_OVER};
	////////////////////////////////////////////////////////////////////////////////
	job_status_error_report i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat),
		.wb_sel_i(wb_sel), .wb_we_i(wb_we), .wb_stb_i(wb_stb), .wb_cyc_i(wb_cyc), .wb_dat_o(wb_rdat),
		.wb_ack_o(wb_ack), .hs_i(hs_req), .xchg_end_i(xchg_end), .hs_o(hs_rsp), .job_i(job_evt),
		.bulk_i(bulk_evt), .partner_flag_i(pflag), .partner_grant_o(grant), .bulk_status_o(bulk_st));
	host_cpu_model i_host (.rsp_i(hs_rsp), .clk_i(clk_i), .req_o(hs_req), .xchg_end_o(xchg_end));
	always #50 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////////////////////
	task final_report;
		$display("Comparisons %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	// The master never assumes the wait state; a lost ack runs into the bench timeout.
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_wdat <= d;
		wb_sel <= 4'hF;
		@(posedge clk_i);
		while (wb_ack !== 1'b1)
			@(posedge clk_i);
		r = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0, q);
		check(q, exp);
	endtask
	task stat(input logic [7:0] j, input logic [31:0] exp);
		wb(1'b1, A_SEL, {24'h0, j}, q);
		rd(A_STAT, exp);
	endtask
	task hs(input hs_kind_e k, input logic [1:0] c, input logic [7:0] j, input logic fok, input fault_e f,
		input logic fin, input logic [7:0] exp);
		logic [7:0] cd;
		i_host.invoke(k, c, j, fok, f, fin, cd);
		check({24'h0, cd}, {24'h0, exp});
		rd(A_PE, {24'h0, exp});
	endtask
	task evt(input job_evt_s e);
		@(posedge clk_i);
		job_evt <= e;
		@(posedge clk_i);
		job_evt <= '0;
	endtask
	task grant_is(input logic [7:0] f, input logic exp);
		pflag <= f;
		repeat (2) @(posedge clk_i);
		check({31'h0, grant}, {31'h0, exp});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			final_report;
		end
	end
	initial begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		{wb_adr, wb_wdat, wb_sel, wb_we, wb_stb, wb_cyc, pflag} = '0;
		job_evt = '0;
		bulk_evt = '0;
		fails = 0;
		samples_checked = 0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(A_STAT, 32'h0);
		rd(A_LEN, 32'h0);
		rd(A_IF, 32'h0);
		rd(8'h18, 32'h0);
		hs(K_SEND, 2'h0, 8'h05, 1'b1, F_NONE, 1'b1, PE_NOT_READY);
		hs(K_SYNC, 2'h0, 8'h00, 1'b0, F_NONE, 1'b1, PE_HS_OTHER);
		hs(K_SYNC, 2'h0, 8'h00, 1'b1, F_NONE, 1'b0, PE_OK);
		hs(K_SEND, 2'h0, 8'h05, 1'b1, F_NONE, 1'b0, PE_REENTRY);
		hs(K_SEND, 2'h1, 8'h05, 1'b1, F_NONE, 1'b1, PE_BUSY);
		rd(A_IF, 32'h80);
		hs(K_RECV, 2'h0, 8'h00, 1'b1, F_NONE, 1'b1, PE_OK);
		hs(K_SEND, 2'h0, 8'h00, 1'b1, F_NONE, 1'b1, PE_OK);
		rd(A_IF, 32'h80);
		for (int i = 0; i < 12; i++)
			hs(K_SEND, 2'h0, 8'h01, 1'b1, fl[i], 1'b1, fc[i]);
		hs(K_SEND, 2'h0, 8'hE0, 1'b1, F_NONE, 1'b1, PE_JOB_BIG);
		hs(K_SEND, 2'h0, 8'h05, 1'b1, F_NONE, 1'b1, PE_OK);
		stat(8'h05, {16'h0, ST_RUNNING});
		rd(A_LEN, 32'h0);
		hs(K_SEND, 2'h0, 8'h05, 1'b1, F_NONE, 1'b1, PE_HS_FAIL);
		evt('{1'b0, 1'b0, 4'h0, 8'h05, 1'b1, 16'h0003, 1'b0});
		evt('{1'b0, 1'b0, 4'h0, 8'h05, 1'b1, 16'h0004, 1'b0});
		rd(A_LEN, 32'h7);
		evt('{1'b0, 1'b1, 4'h9, 8'h05, 1'b0, 16'h0000, 1'b0});
		stat(8'h05, 32'h0908);
		hs(K_FETCH, 2'h0, 8'h06, 1'b1, F_NONE, 1'b1, PE_OK);
		evt('{1'b1, 1'b0, 4'h0, 8'h06, 1'b0, 16'h0000, 1'b0});
		stat(8'h06, {16'h0, ST_DONE_OK});
		// Twenty accepted jobs fill the queue; the next one must be refused.
		for (int j = 10; j < 30; j++)
			hs(j[0] ? K_FETCH : K_SEND, 2'h0, j[7:0], 1'b1, F_NONE, 1'b1, PE_OK);
		rd(A_IF, 32'h94);
		hs(K_SEND, 2'h0, 8'h1E, 1'b1, F_NONE, 1'b1, PE_HS_FAIL);
		stat(8'h1E, {16'h0, 4'h0, ST_QFULL, 8'h08});
		for (int i = 0; i < 5; i++) begin
			evt('{1'b0, 1'b0, 4'h0, sp[i], 1'b0, 16'h0000, 1'b1});
			stat(sp[i], {16'h0, ST_LONG_DEST, 8'h08});
		end
		for (int i = 0; i < 7; i++) begin
			bulk_evt <= bt[i];
			repeat (2) @(posedge clk_i);
			check({24'h0, bulk_st}, {24'h0, bx[i]});
		end
		bulk_evt <= '0;
		wb(1'b1, 8'h20, 32'h8, q);
		grant_is(8'h03, 1'b0);
		grant_is(8'h04, 1'b1);
		wb(1'b1, 8'h20, 32'h0, q);
		grant_is(8'h03, 1'b1);
		hs(K_SYNC, 2'h0, 8'h00, 1'b1, F_NONE, 1'b1, PE_OK);
		stat(8'h1E, 32'h0);
		rd(A_IF, 32'h80);
		final_report;
	end
endmodule // job_status_error_report_test
`default_nettype wire
